// ==== design/sfrws_regs.svh ====
// Opcodes, frame lengths, geometry and timing constants of the flash sequencer
`ifndef SFRWS_REGS_SVH
`define SFRWS_REGS_SVH

// =====================================================================
// Opcodes
`define SFRWS_OP_READ    8'h03
`define SFRWS_OP_FAST    8'h0b
`define SFRWS_OP_PROG    8'h02
`define SFRWS_OP_REGION  8'hd8
`define SFRWS_OP_ARRAY   8'hc7
`define SFRWS_OP_SLEEP   8'hb9
`define SFRWS_OP_UNLOCK  8'h06

// =====================================================================
// Frame lengths in link bits
`define SFRWS_OP_BITS    16'h0008
`define SFRWS_ADDR_END   16'h0020
`define SFRWS_DUMMY_END  16'h0028
`define SFRWS_CNT_WRAP   16'h8000

// =====================================================================
// Geometry
`define SFRWS_MEM_AW     20
`define SFRWS_REGION_AW  16
`define SFRWS_PAGE_AW    8
`define SFRWS_ERASED     8'hff

// =====================================================================
// Timing
`define SFRWS_CLK_NS          10
`define SFRWS_PAGE_WRITE_US   5000
`define SFRWS_REGION_CLEAR_US 3000000
`define SFRWS_ARRAY_CLEAR_US  20000000
`define SFRWS_SLEEP_ENTRY_US  3

`endif

// ==== design/sfrws_pkg.sv ====
// Types shared by the flash sequencer modules
package sfrws_pkg;

  // ===================================================================
  // Core sequencer states
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_work  = 2'b01,
    st_enter = 2'b10,
    st_sleep = 2'b11
  } sfrws_state_t;

  // ===================================================================
  // Link side state, one page of program data included
  typedef struct packed {
    logic [15:0]   cnt;
    logic [7:0]    op;
    logic [23:0]   addr;
    logic [7:0]    sh;
    logic [7:0]    pidx;
    logic [23:0]   rd_addr;
    logic [2047:0] pbuf;
    logic [255:0]  pmask;
    logic          seq;
    logic          rs1;
    logic          rs2;
  } sfrws_link_t;

endpackage : sfrws_pkg

// ==== design/sfrws_link.sv ====
// Link-clock side of the flash sequencer: shifter, page buffer, read out
`include "sfrws_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sfrws_link (
  // Link pins
  input  wire logic          sck,
  input  wire logic          cs_n,
  input  wire logic          mosi,
  output var  logic          miso,
  output var  logic          miso_oe,
  // Core side
  input  wire logic          core_refuse,
  input  wire logic [7:0]    rd_data,
  output logic      [23:0]   rd_addr,
  output logic      [7:0]    lk_op,
  output logic      [23:0]   lk_addr,
  output logic               lk_end_op,
  output logic               lk_end_addr,
  output logic               lk_end_data,
  output logic      [2047:0] lk_pbuf,
  output logic      [255:0]  lk_pmask,
  output logic               lk_seq
);

  sfrws_pkg::sfrws_link_t s;
  sfrws_pkg::sfrws_link_t next_s;
  logic                   fresh;
  logic [15:0]            base;
  logic                   reading;

  // ===================================================================
  // Frame start marker: link clock is still outside frames
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // ===================================================================
  // Shifter and page buffer
  always_comb begin
    next_s = s;
    base = fresh ? 16'h0000 : s.cnt;
    next_s.rs1 = core_refuse;
    next_s.rs2 = s.rs1;
    // A branch, not an inversion, so an unknown power-up value settles
    if (fresh && s.seq) begin
      next_s.seq = 1'b0;
    end else if (fresh) begin
      next_s.seq = 1'b1;
    end
    // Wrap keeps byte alignment in endless reads
    next_s.cnt = (base == 16'hffff) ? `SFRWS_CNT_WRAP : base + 16'h0001;
    next_s.sh = {s.sh[6:0], mosi};
    if (base < `SFRWS_OP_BITS) begin
      next_s.op = {s.op[6:0], mosi};
    end else if (base < `SFRWS_ADDR_END) begin
      next_s.addr = {s.addr[22:0], mosi};
    end
    // Buffer untouched while busy so a running program keeps its data
    if (base == 16'h0007 && next_s.op == `SFRWS_OP_PROG && !s.rs2) begin
      next_s.pmask = '0;
    end
    if (base == 16'h001f) begin
      next_s.pidx = next_s.addr[7:0];
    end
    if (s.op == `SFRWS_OP_PROG && base >= 16'h0027 && base[2:0] == 3'h7
        && !s.rs2) begin
      next_s.pbuf[{s.pidx, 3'b000} +: 8] = next_s.sh;
      next_s.pmask[s.pidx] = 1'b1;
      next_s.pidx = s.pidx + 8'h01;
    end
    if (s.op == `SFRWS_OP_READ && base == 16'h001f) begin
      next_s.rd_addr = next_s.addr;
    end else if (s.op == `SFRWS_OP_FAST && base == 16'h0027) begin
      next_s.rd_addr = s.addr;
    end else if (((s.op == `SFRWS_OP_READ && base >= 16'h0027)
                 || (s.op == `SFRWS_OP_FAST && base >= 16'h002f))
                 && base[2:0] == 3'h7) begin
      next_s.rd_addr = s.rd_addr + 24'h000001;
    end
  end

  always_ff @(posedge sck) begin
    s <= next_s;
  end

  // ===================================================================
  // Read data out on the falling edge
  assign reading = !fresh && !s.rs2
                   && ((s.op == `SFRWS_OP_READ && s.cnt >= `SFRWS_ADDR_END)
                   || (s.op == `SFRWS_OP_FAST && s.cnt >= `SFRWS_DUMMY_END));

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso    <= rd_data[~s.cnt[2:0]];
      miso_oe <= reading;
    end
  end

  // ===================================================================
  // Summary, stable while the link clock stands between frames
  assign rd_addr     = s.rd_addr;
  assign lk_op       = s.op;
  assign lk_addr     = s.addr;
  assign lk_end_op   = (s.cnt == `SFRWS_OP_BITS);
  assign lk_end_addr = (s.cnt == `SFRWS_ADDR_END);
  assign lk_end_data = (s.cnt >= `SFRWS_DUMMY_END) && (s.cnt[2:0] == 3'h0);
  assign lk_pbuf     = s.pbuf;
  assign lk_pmask    = s.pmask;
  assign lk_seq      = s.seq;

  // ===================================================================
  // Checks on the link clock
  chk_read_advance: assert property
    (@(posedge sck) disable iff (cs_n)
    (!fresh && s.op == `SFRWS_OP_READ && s.cnt >= 16'h0027
     && s.cnt[2:0] == 3'h7)
    |=> rd_addr == $past(rd_addr) + 24'h000001)
    else $error("read address did not advance after a byte");

  chk_op_msb_first: assert property
    (@(posedge sck) disable iff (cs_n)
    (!fresh && s.cnt == 16'h0007) |=> lk_op[0] == $past(mosi))
    else $error("opcode not taken msb first");

endmodule : sfrws_link

`default_nettype wire

// ==== design/sfrws_top.sv ====
// Serial flash command sequencer: reads, program, clears and deep sleep
//
// Function
// - Normal read: opcode, 3 address bytes in on rise, data out on fall
// - Quick read adds one dummy byte before data comes out
// - Read address advances per byte and wraps to zero past the top
// - Top four address bits are ignored for every command
// - Chip select high ends a read and stops output drive
// - Reads are refused while a self-timed cycle runs
// - Program and clears need the write unlock latch set
// - Program data past page end wraps to page start
// - More than 256 program bytes: only the last 256 are kept
// - Fewer than 256 bytes: other page bytes stay unchanged
// - Programming only turns ones into zeros
// - Program runs on exact byte end; busy set, latch cleared early
// - Program into a protected page is not executed
// - Region clear sets every byte of the addressed region to ff
// - Region clear needs exactly 32 bits; busy set, latch cleared
// - Region clear of a protected region is not executed
// - Whole clear is the bare opcode, exactly 8 bits, then busy
// - Whole clear only when the protect level is zero
// - Sleep entry is the bare opcode, sleep after the entry delay
// - Asleep, every command except wake is ignored
// - Sleep entry is refused while a self-timed cycle runs
// - Idle deselect means standby; reset starts in standby
// - Busy flag is readable at all times
// - Latch clear refuses status write, program and clears
`include "sfrws_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sfrws_top #(
  parameter int          MEM_AW           = `SFRWS_MEM_AW,
  parameter int          REGION_AW        = `SFRWS_REGION_AW,
  parameter logic [31:0] PAGE_WRITE_CYC   =
    32'(`SFRWS_PAGE_WRITE_US * (1000 / `SFRWS_CLK_NS)),
  parameter logic [31:0] REGION_CLEAR_CYC =
    32'(`SFRWS_REGION_CLEAR_US * (1000 / `SFRWS_CLK_NS)),
  parameter logic [31:0] ARRAY_CLEAR_CYC  =
    32'(`SFRWS_ARRAY_CLEAR_US * (1000 / `SFRWS_CLK_NS))
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Link pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output var  logic       miso,
  output var  logic       miso_oe,
  // Device-wide state
  input  wire logic [2:0] protect_level_bits,
  input  wire logic       status_write_busy,
  input  wire logic       wake_request,
  output logic            busy_flag,
  output logic            write_unlock_latch,
  output logic            deep_sleep,
  output logic            standby
);

  // ===================================================================
  // Derived constants
  localparam logic [31:0] SLEEP_CYC =
    32'(`SFRWS_SLEEP_ENTRY_US * (1000 / `SFRWS_CLK_NS));
  localparam logic [MEM_AW:0] PAGE_SPAN   =
    (MEM_AW + 1)'(1) << `SFRWS_PAGE_AW;
  localparam logic [MEM_AW:0] REGION_SPAN = (MEM_AW + 1)'(1) << REGION_AW;
  localparam logic [MEM_AW:0] ARRAY_SPAN  = (MEM_AW + 1)'(1) << MEM_AW;
  // Protection is top aligned, so the last byte of a span decides it
  localparam logic [MEM_AW-1:0] PAGE_MASK   = MEM_AW'(PAGE_SPAN - 1);
  localparam logic [MEM_AW-1:0] REGION_MASK = MEM_AW'(REGION_SPAN - 1);

  typedef struct packed {
    sfrws_pkg::sfrws_state_t st;
    logic                    cs1;
    logic                    cs2;
    logic                    cs3;
    logic                    seen;
    logic                    wul;
    logic                    prog;
    logic [31:0]             tmr;
    logic [MEM_AW:0]         ptr;
    logic [MEM_AW:0]         span;
    logic [MEM_AW-1:0]       base;
  } sfrws_main_t;

  sfrws_main_t s;
  sfrws_main_t next_s;

  // ===================================================================
  // Link side wiring
  logic [23:0]       rd_addr;
  logic [7:0]        rd_data;
  logic [7:0]        lk_op;
  logic [23:0]       lk_addr;
  logic              lk_end_op;
  logic              lk_end_addr;
  logic              lk_end_data;
  logic [2047:0]     lk_pbuf;
  logic [255:0]      lk_pmask;
  logic              lk_seq;
  logic              busy_any;
  logic              cs_rise;
  logic              new_frame;
  logic [MEM_AW-1:0] a;
  logic              go;
  logic              go_prog;
  logic [MEM_AW-1:0] go_base;
  logic [MEM_AW:0]   go_span;
  logic [31:0]       go_cyc;

  // ===================================================================
  // Memory array, flip-flops addressed by index
  logic [7:0]        mem [2**MEM_AW];
  logic [MEM_AW-1:0] wr_idx;
  logic              wr_en;
  logic [7:0]        wr_byte;

  // Array only changes inside busy cycles, when reads are refused,
  // so the link may read it without a crossing.
  assign rd_data = mem[rd_addr[MEM_AW-1:0]];

  sfrws_link u_link (
    .sck         (sck),
    .cs_n        (cs_n),
    .mosi        (mosi),
    .miso        (miso),
    .miso_oe     (miso_oe),
    .core_refuse (busy_any || deep_sleep),
    .rd_data     (rd_data),
    .rd_addr     (rd_addr),
    .lk_op       (lk_op),
    .lk_addr     (lk_addr),
    .lk_end_op   (lk_end_op),
    .lk_end_addr (lk_end_addr),
    .lk_end_data (lk_end_data),
    .lk_pbuf     (lk_pbuf),
    .lk_pmask    (lk_pmask),
    .lk_seq      (lk_seq)
  );

  // ===================================================================
  // Protection decode: protected span is the top of the array
  function automatic logic prot_hit(input logic [2:0]        lvl,
                                    input logic [MEM_AW-1:0] addr);
    logic [MEM_AW-1:0] low;
    low = ~({MEM_AW{1'b1}} >> (3'h7 - lvl));
    if (lvl == 3'h0) begin
      prot_hit = 1'b0;
    end else begin
      prot_hit = (addr >= low);
    end
  endfunction : prot_hit

  // ===================================================================
  // Sequencer
  always_comb begin
    next_s    = s;
    busy_any  = (s.st == sfrws_pkg::st_work) || status_write_busy;
    cs_rise   = s.cs2 && !s.cs3;
    new_frame = cs_rise && (lk_seq != s.seen);
    a         = lk_addr[MEM_AW-1:0];
    go        = 1'b0;
    go_prog   = 1'b0;
    go_base   = '0;
    go_span   = '0;
    go_cyc    = '0;
    next_s.cs1 = cs_n;
    next_s.cs2 = s.cs1;
    next_s.cs3 = s.cs2;
    if (cs_rise) begin
      next_s.seen = lk_seq;
    end
    case (s.st)
      sfrws_pkg::st_idle: begin
        if (new_frame && !busy_any) begin
          if (lk_op == `SFRWS_OP_UNLOCK && lk_end_op) begin
            next_s.wul = 1'b1;
          end else if (lk_op == `SFRWS_OP_PROG && lk_end_data && s.wul
                       && !prot_hit(protect_level_bits, a | PAGE_MASK)) begin
            go      = 1'b1;
            go_prog = 1'b1;
            go_base = {a[MEM_AW-1:`SFRWS_PAGE_AW],
                       {`SFRWS_PAGE_AW{1'b0}}};
            go_span = PAGE_SPAN;
            go_cyc  = PAGE_WRITE_CYC;
          end else if (lk_op == `SFRWS_OP_REGION && lk_end_addr && s.wul
                       && !prot_hit(protect_level_bits, a | REGION_MASK)) begin
            go      = 1'b1;
            go_base = a & ~(MEM_AW'(REGION_SPAN) - MEM_AW'(1));
            go_span = REGION_SPAN;
            go_cyc  = REGION_CLEAR_CYC;
          end else if (lk_op == `SFRWS_OP_ARRAY && lk_end_op && s.wul
                       && protect_level_bits == 3'h0) begin
            go      = 1'b1;
            go_span = ARRAY_SPAN;
            go_cyc  = ARRAY_CLEAR_CYC;
          end else if (lk_op == `SFRWS_OP_SLEEP && lk_end_op) begin
            next_s.st  = sfrws_pkg::st_enter;
            next_s.tmr = SLEEP_CYC - 32'h1;
          end
        end
        if (go) begin
          next_s.st   = sfrws_pkg::st_work;
          next_s.wul  = 1'b0;
          next_s.prog = go_prog;
          next_s.base = go_base;
          next_s.span = go_span;
          next_s.ptr  = '0;
          next_s.tmr  = go_cyc - 32'h1;
        end
      end
      sfrws_pkg::st_work: begin
        // Byte walk runs inside the timed window; a short window waits
        // for the walk to finish rather than cut it.
        if (s.ptr < s.span) begin
          next_s.ptr = s.ptr + (MEM_AW + 1)'(1);
        end
        if (s.tmr != 32'h0) begin
          next_s.tmr = s.tmr - 32'h1;
        end else if (s.ptr >= s.span) begin
          next_s.st = sfrws_pkg::st_idle;
        end
      end
      sfrws_pkg::st_enter: begin
        if (s.tmr == 32'h0) begin
          next_s.st = sfrws_pkg::st_sleep;
        end else begin
          next_s.tmr = s.tmr - 32'h1;
        end
      end
      sfrws_pkg::st_sleep: begin
        if (wake_request) begin
          next_s.st = sfrws_pkg::st_idle;
        end
      end
      default: begin
        next_s.st = sfrws_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s      <= '0;
      s.cs1  <= 1'b1;
      s.cs2  <= 1'b1;
      s.cs3  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ===================================================================
  // Array writes during the busy window
  always_comb begin
    wr_en   = (s.st == sfrws_pkg::st_work) && (s.ptr < s.span);
    wr_idx  = s.base + s.ptr[MEM_AW-1:0];
    wr_byte = `SFRWS_ERASED;
    if (s.prog) begin
      wr_idx  = {s.base[MEM_AW-1:`SFRWS_PAGE_AW],
                 s.ptr[`SFRWS_PAGE_AW-1:0]};
      wr_en   = wr_en && lk_pmask[s.ptr[7:0]];
      wr_byte = mem[wr_idx] & lk_pbuf[{s.ptr[7:0], 3'b000} +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_byte;
    end
  end

  // ===================================================================
  // Outputs
  assign busy_flag          = (s.st == sfrws_pkg::st_work);
  assign write_unlock_latch = s.wul;
  assign deep_sleep         = (s.st == sfrws_pkg::st_sleep);
  assign standby            = s.cs2 && (s.st == sfrws_pkg::st_idle)
                              && !status_write_busy;

  // ===================================================================
  // Checks
  logic in_enter;
  logic idle_free;
  logic full_span;
  assign in_enter  = (s.st == sfrws_pkg::st_enter);
  assign idle_free = !busy_any;
  assign full_span = (s.span == ARRAY_SPAN);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_unlock_needed: assert property
    ($rose(busy_flag) |-> $past(write_unlock_latch))
    else $error("cycle started without unlock latch");

  chk_latch_cleared: assert property
    ($rose(busy_flag) |-> !write_unlock_latch)
    else $error("unlock latch still set in cycle");

  chk_busy_holds: assert property
    ($rose(busy_flag) |-> busy_flag [*8])
    else $error("self-timed cycle ended too early");

  chk_array_guard: assert property
    (($rose(busy_flag) && full_span) |-> $past(protect_level_bits) == 3'h0)
    else $error("whole clear under protection");

  chk_page_guard: assert property
    (($rose(busy_flag) && s.prog)
    |-> !prot_hit($past(protect_level_bits), s.base))
    else $error("program into protected page");

  chk_sleep_delay: assert property
    ($rose(deep_sleep) |-> $past(in_enter, 300))
    else $error("sleep entered before entry delay");

  chk_sleep_refused: assert property
    ($rose(in_enter) |-> $past(idle_free))
    else $error("sleep accepted during busy cycle");

  chk_sleep_quiet: assert property
    (deep_sleep |=> !busy_flag && !$rose(write_unlock_latch))
    else $error("command acted on while asleep");

  chk_standby_idle: assert property
    (standby |-> !busy_flag && !deep_sleep)
    else $error("standby shown while busy or asleep");

  cov_program: cover property ($rose(busy_flag) && s.prog);
  cov_region:  cover property ($rose(busy_flag) && s.span == REGION_SPAN);
  cov_sleep:   cover property ($rose(deep_sleep));
  cov_wake:    cover property ($fell(deep_sleep));

endmodule : sfrws_top

`default_nettype wire

// ==== verification/sfrws_host.sv ====
// Host link controller model: chip select, link clock and data out
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Host model
module sfrws_host (
  // Link pins
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] rx;

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
    rx   = 8'h00;
  end

  // Clock runs only inside frames; msb first
  task xbyte(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #15 sck = 1'b1;
      rx = {rx[6:0], miso};
      #15 sck = 1'b0;
    end
  endtask : xbyte

  // Odd offset keeps the link unrelated in phase to the core clock
  task fr_open;
    #7 cs_n = 1'b0;
    #8;
  endtask : fr_open

  // Deselect right after the last bit
  // Released data line flips so a stale bit is never mistaken for data
  task fr_close;
    #15 cs_n = 1'b1;
    mosi = ~mosi;
    #70;
  endtask : fr_close
endmodule : sfrws_host
`default_nettype wire

// ==== verification/serial_flash_read_write_sleep_tb.sv ====
// Self-checking bench of the flash sequencer against a host link model
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Bench
module serial_flash_read_write_sleep_tb;
  logic       clk;
  logic       reset;
  logic       sck;
  logic       cs_n;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  logic       swb;
  logic       wake;
  logic       busy;
  logic       latch;
  logic       sleep;
  logic       stby;
  logic [2:0] lvl;
  logic [7:0] mem [0:1023];
  logic [7:0] pop [3] = '{8'h02, 8'hd8, 8'hc7};
  int         plen [3] = '{4, 3, 0};
  int         err_count, comparisons;
  logic [23:0] a;
  int          n;

  sfrws_host host_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // Short cycle counts keep the run small
  sfrws_top #(.MEM_AW(10), .REGION_AW(9), .PAGE_WRITE_CYC(32'h12c),
    .REGION_CLEAR_CYC(32'h12c), .ARRAY_CLEAR_CYC(32'h800)) sfrws_top_inst (
    .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .protect_level_bits(lvl),
    .status_write_busy(swb), .wake_request(wake), .busy_flag(busy),
    .write_unlock_latch(latch), .deep_sleep(sleep), .standby(stby));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // =====================================================================
  // Checking and closing
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task clks(input int k);
    repeat (k) @(posedge clk);
  endtask : clks

  // Bounded wait on busy or sleep
  task wait_on(input bit slp, input logic val);
    int k;
    k = 0;
    while ((slp ? sleep : busy) !== val && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (k == 4000) begin
      err_count++;
      $display("wrong value at %0t: wait ran out", $time);
      final_report;
    end
  endtask : wait_on

  // =====================================================================
  // Frames
  task cmd(input logic [7:0] op);
    host_inst.fr_open;
    host_inst.xbyte(op);
    host_inst.fr_close;
  endtask : cmd

  // Top nibble is noise the device must ignore
  task hdr(input logic [7:0] op, input logic [23:0] ad);
    ad[23:20] = 4'($urandom);
    host_inst.fr_open;
    host_inst.xbyte(op);
    for (int i = 2; i >= 0; i--) host_inst.xbyte(ad[8*i +: 8]);
  endtask : hdr

  function automatic logic [9:0] pg(input logic [23:0] ad, input int k);
    return {ad[9:8], 8'(ad[7:0] + k)};
  endfunction : pg

  task rd(input logic [7:0] op, input logic [23:0] ad, input int k);
    hdr(op, ad);
    if (op == 8'h0b) host_inst.xbyte(8'h00);
    for (int i = 0; i < k; i++) begin
      host_inst.xbyte(8'h00);
      check(host_inst.rx, mem[10'(ad[9:0] + i)]);
    end
    host_inst.fr_close;
    check(miso_oe, 1'b0);
  endtask : rd

  // Only the last 256 bytes count, wrapped in page, ANDed in
  task prog(input logic [23:0] ad, input int k);
    logic [7:0] d;
    cmd(8'h06);
    hdr(8'h02, ad);
    for (int i = 0; i < k; i++) begin
      d = 8'($urandom);
      host_inst.xbyte(d);
      if (i + 256 >= k) mem[pg(ad, i)] &= d;
    end
    host_inst.fr_close;
  endtask : prog

  // =====================================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    lvl = 3'h0;
    swb = 1'b0;
    wake = 1'b0;
    err_count = 0;
    comparisons = 0;
    void'($urandom(35));
    clks(2);
    reset <= 1'b0;
    clks(1);
    check(busy, 1'b0);
    check(latch, 1'b0);
    check(sleep, 1'b0);
    check(stby, 1'b1);
    swb <= 1'b1;
    clks(2);
    check(stby, 1'b0);
    swb <= 1'b0;
    cmd(8'h00);
    cmd(8'h06);
    check(latch, 1'b1);
    cmd(8'hc7);
    check(busy, 1'b1);
    check(latch, 1'b0);
    wait_on(1'b0, 1'b0);
    foreach (mem[i]) mem[i] = 8'hff;
    rd(8'h03, 24'($urandom % 1024), 3);
    $display("test whole clear done");
    // No unlock: program refused
    hdr(8'h02, 24'h000010);
    host_inst.xbyte(8'h00);
    host_inst.fr_close;
    check(busy, 1'b0);
    // Whole clear with a stray byte is dropped
    cmd(8'h06);
    host_inst.fr_open;
    host_inst.xbyte(8'hc7);
    host_inst.xbyte(8'h00);
    host_inst.fr_close;
    check(busy, 1'b0);
    $display("test refusals done");
    // Long program from mid page, then a read while busy
    a = {14'h0, 2'($urandom), 8'hf0};
    prog(a, 260);
    hdr(8'h03, a);
    host_inst.xbyte(8'h00);
    check(miso_oe, 1'b0);
    host_inst.fr_close;
    check(busy, 1'b1);
    wait_on(1'b0, 1'b0);
    rd(8'h03, {a[23:8], 8'h00}, 256);
    $display("test page wrap done");
    for (int k = 0; k < 4; k++) begin
      a = 24'($urandom % 1024);
      n = 1 + $urandom % 20;
      prog(a, n);
      wait_on(1'b0, 1'b0);
      rd(k[0] ? 8'h0b : 8'h03, 24'(10'(a - 2)), n + 4);
    end
    rd(8'h03, 24'h0003fe, 4);
    $display("test short programs done");
    a = 24'($urandom % 1024);
    cmd(8'h06);
    hdr(8'hd8, a);
    host_inst.fr_close;
    check(busy, 1'b1);
    wait_on(1'b0, 1'b0);
    for (int i = 0; i < 512; i++) mem[{a[9], 9'(i)}] = 8'hff;
    rd(8'h03, {14'h0, a[9], 9'h1fe}, 4);
    $display("test region clear done");
    @(posedge clk) lvl <= 3'h7;
    for (int k = 0; k < 3; k++) begin
      cmd(8'h06);
      host_inst.fr_open;
      host_inst.xbyte(pop[k]);
      for (int j = 0; j < plen[k]; j++) host_inst.xbyte(8'h00);
      host_inst.fr_close;
      check(busy, 1'b0);
    end
    @(posedge clk) lvl <= 3'h0;
    rd(8'h0b, 24'h0, 4);
    $display("test protection done");
    cmd(8'h06);
    cmd(8'hc7);
    cmd(8'hb9);
    wait_on(1'b0, 1'b0);
    clks(400);
    check(sleep, 1'b0);
    foreach (mem[i]) mem[i] = 8'hff;
    cmd(8'hb9);
    clks(250);
    check(sleep, 1'b0);
    wait_on(1'b1, 1'b1);
    cmd(8'h06);
    check(latch, 1'b0);
    hdr(8'h03, 24'h0);
    host_inst.xbyte(8'h00);
    check(miso_oe, 1'b0);
    host_inst.fr_close;
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    clks(2);
    check(sleep, 1'b0);
    rd(8'h03, 24'h0, 2);
    $display("test deep sleep done");
    final_report;
  end
endmodule : serial_flash_read_write_sleep_tb
`default_nettype wire
